// ===== hw/pief_defines.svh
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

`define PIEF_OFF_CTRL      8'h00
`define PIEF_OFF_EN_A      8'h04
`define PIEF_OFF_EN_B      8'h08
`define PIEF_OFF_PEND_A    8'h0C
`define PIEF_OFF_PEND_B    8'h10
`define PIEF_OFF_STS       8'h14
`define PIEF_OFF_MASK      8'h18

`define PIEF_BIT_ALL_EN    7
`define PIEF_BIT_PERIPH_EN 6
`define PIEF_LANE0         0
`define PIEF_B_HI          7
`define PIEF_B_LO          3

`define PIEF_PEND_A_WMASK  8'hCF
`define PIEF_RST8          8'h00
`define PIEF_RST5          5'h00
`define PIEF_RST2          2'h0
`define PIEF_RST32         32'h0000_0000
`define PIEF_PAD3          3'h0
`define PIEF_PAD6          6'h00
`define PIEF_PAD24         24'h00_0000

`define PIEF_STS_REQ_RISE  0
`define PIEF_STS_UNEN_EVT  1

`endif

// ===== hw/pief_pkg.sv
package pief_pkg;

   typedef struct packed {
      logic t1_gate_acq;
      logic adc_done;
      logic uart_rx;
      logic uart_tx;
      logic sync_serial;
      logic capcmp1;
      logic t2_match;
      logic t1_overflow;
   } pief_src_a_t;

   typedef struct packed {
      logic osc_fail;
      logic cmp2;
      logic cmp1;
      logic eeprom_write_done;
      logic bus_collision;
   } pief_src_b_t;

   typedef enum logic {
      PIEF_APB_IDLE,
      PIEF_APB_ANSWER
   } pief_apb_st_t;

endpackage

// ===== hw/pief_top.sv
`timescale 1ns/1ps
`include "pief_defines.svh"

module pief_top (
   input  wire logic                 MCLK,
   input  wire logic                 RESETN,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire logic [31:0]          PWDATA,
   input  wire logic [3:0]           PSTRB,
   output logic                      PREADY,
   output logic [31:0]               PRDATA,
   output logic                      PSLVERR,
   input  wire pief_pkg::pief_src_a_t EVT_A,
   input  wire pief_pkg::pief_src_b_t EVT_B,
   input  wire logic                 IRQ_ENTRY,
   input  wire logic                 IRQ_RETURN,
   output logic                      PERIPH_IRQ_REQ,
   output logic                      CORE_IRQ_REQ,
   output logic                      IRQ
);

   // bus state
   pief_pkg::pief_apb_st_t st_r;
   pief_pkg::pief_apb_st_t st_nxt;
   logic                   pready_r;
   logic [31:0]            prdata_r;
   logic                   pslverr_r;

   // register state
   logic                   all_irq_en_r;
   logic                   all_irq_en_nxt;
   logic                   periph_irq_global_en_r;
   logic                   periph_irq_global_en_nxt;
   logic [7:0]             enable_a_r;
   logic [7:0]             enable_a_nxt;
   logic [4:0]             enable_b_r;
   logic [4:0]             enable_b_nxt;
   logic [7:0]             pending_a_r;
   logic [7:0]             pending_a_nxt;
   logic [4:0]             pending_b_r;
   logic [4:0]             pending_b_nxt;
   logic [1:0]             sts_r;
   logic [1:0]             sts_nxt;
   logic [1:0]             mask_r;
   logic [1:0]             mask_nxt;

   // registered outputs
   logic                   periph_req_r;
   logic                   core_req_r;
   logic                   irq_r;

   // decode wires
   wire                    acc_phase;
   wire                    sel_ctrl;
   wire                    sel_en_a;
   wire                    sel_en_b;
   wire                    sel_pend_a;
   wire                    sel_pend_b;
   wire                    sel_sts;
   wire                    sel_mask;
   wire                    hit;
   wire                    commit;
   wire                    wr_ok;
   wire [7:0]              wlane;
   wire                    wr_ctrl;
   wire                    wr_en_a;
   wire                    wr_en_b;
   wire                    wr_pend_a;
   wire                    wr_pend_b;
   wire                    wr_sts;
   wire                    wr_mask;

   // event and request wires
   wire [7:0]              evt_a_bits;
   wire [4:0]              evt_b_bits;
   wire [7:0]              pend_a_sw;
   wire [4:0]              pend_b_sw;
   wire                    req_any;
   wire                    periph_req;
   wire                    core_req;
   wire [1:0]              sts_set;
   wire [1:0]              sts_clr;
   wire                    unen_evt;

   // read path wires
   wire [7:0]              rd_ctrl;
   wire [7:0]              rd_en_b;
   wire [7:0]              rd_pend_b;
   wire [7:0]              rd_sts;
   wire [7:0]              rd_mask;
   wire [7:0]              rd_byte;
   wire [31:0]             rd_word;

   // address decode
   assign acc_phase  = PSEL & PENABLE;
   assign sel_ctrl   = (PADDR == `PIEF_OFF_CTRL);
   assign sel_en_a   = (PADDR == `PIEF_OFF_EN_A);
   assign sel_en_b   = (PADDR == `PIEF_OFF_EN_B);
   assign sel_pend_a = (PADDR == `PIEF_OFF_PEND_A);
   assign sel_pend_b = (PADDR == `PIEF_OFF_PEND_B);
   assign sel_sts    = (PADDR == `PIEF_OFF_STS);
   assign sel_mask   = (PADDR == `PIEF_OFF_MASK);
   assign hit        = sel_ctrl | sel_en_a | sel_en_b | sel_pend_a
                     | sel_pend_b | sel_sts | sel_mask;

   // write strobes, taken at the edge that samples pready
   assign commit    = acc_phase & pready_r & (st_r == pief_pkg::PIEF_APB_ANSWER);
   assign wr_ok     = commit & PWRITE & PSTRB[`PIEF_LANE0];
   assign wlane     = PWDATA[7:0];
   assign wr_ctrl   = wr_ok & sel_ctrl;
   assign wr_en_a   = wr_ok & sel_en_a;
   assign wr_en_b   = wr_ok & sel_en_b;
   assign wr_pend_a = wr_ok & sel_pend_a;
   assign wr_pend_b = wr_ok & sel_pend_b;
   assign wr_sts    = wr_ok & sel_sts;
   assign wr_mask   = wr_ok & sel_mask;

   // event vectors
   assign evt_a_bits = EVT_A;
   assign evt_b_bits = EVT_B;

   // global enables, core entry clears and return sets all_irq_en_r only
   assign all_irq_en_nxt = IRQ_ENTRY ? 1'b0 :
                           IRQ_RETURN ? 1'b1 :
                           wr_ctrl ? wlane[`PIEF_BIT_ALL_EN] : all_irq_en_r;
   assign periph_irq_global_en_nxt = wr_ctrl ? wlane[`PIEF_BIT_PERIPH_EN]
                                             : periph_irq_global_en_r;

   assign enable_a_nxt = wr_en_a ? wlane : enable_a_r;

   assign enable_b_nxt = wr_en_b ? wlane[`PIEF_B_HI:`PIEF_B_LO] : enable_b_r;

   assign pend_a_sw = wr_pend_a ? (wlane & `PIEF_PEND_A_WMASK)
                                : (pending_a_r & `PIEF_PEND_A_WMASK);

   assign pending_a_nxt = pend_a_sw | evt_a_bits;

   assign pend_b_sw = wr_pend_b ? wlane[`PIEF_B_HI:`PIEF_B_LO] : pending_b_r;

   assign pending_b_nxt = pend_b_sw | evt_b_bits;

   assign req_any = (|(pending_a_r & enable_a_r)) | (|(pending_b_r & enable_b_r));

   assign periph_req = periph_irq_global_en_r & req_any;

   assign core_req = all_irq_en_r & periph_req;

   // block status events
   assign unen_evt = (|(evt_a_bits & ~enable_a_r)) | (|(evt_b_bits & ~enable_b_r));
   assign sts_set  = {unen_evt, periph_req & ~periph_req_r};
   assign sts_clr  = wr_sts ? wlane[1:0] : `PIEF_RST2;
   assign sts_nxt  = (sts_r & ~sts_clr) | sts_set;
   assign mask_nxt = wr_mask ? wlane[1:0] : mask_r;

   assign rd_ctrl   = {all_irq_en_r, periph_irq_global_en_r, `PIEF_PAD6};
   assign rd_en_b   = {enable_b_r, `PIEF_PAD3};
   assign rd_pend_b = {pending_b_r, `PIEF_PAD3};
   assign rd_sts    = {`PIEF_PAD6, sts_r};
   assign rd_mask   = {`PIEF_PAD6, mask_r};

   // read select
   assign rd_byte = sel_ctrl   ? rd_ctrl :
                    sel_en_a   ? enable_a_r :
                    sel_en_b   ? rd_en_b :
                    sel_pend_a ? pending_a_r :
                    sel_pend_b ? rd_pend_b :
                    sel_sts    ? rd_sts :
                    sel_mask   ? rd_mask : `PIEF_RST8;
   assign rd_word = {`PIEF_PAD24, rd_byte};

   // bus sequencing, one wait state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         pief_pkg::PIEF_APB_IDLE: begin
            if (acc_phase) begin
               st_nxt = pief_pkg::PIEF_APB_ANSWER;
            end
         end
         pief_pkg::PIEF_APB_ANSWER: begin
            st_nxt = pief_pkg::PIEF_APB_IDLE;
         end
         default: begin
            st_nxt = pief_pkg::PIEF_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         st_r <= pief_pkg::PIEF_APB_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // answer registers
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_r  <= 1'b0;
         prdata_r  <= `PIEF_RST32;
         pslverr_r <= 1'b0;
      end else if ((st_r == pief_pkg::PIEF_APB_IDLE) && acc_phase) begin
         pready_r  <= 1'b1;
         prdata_r  <= PWRITE ? `PIEF_RST32 : rd_word;
         pslverr_r <= ~hit;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         all_irq_en_r           <= 1'b0;
         periph_irq_global_en_r <= 1'b0;
      end else begin
         all_irq_en_r           <= all_irq_en_nxt;
         periph_irq_global_en_r <= periph_irq_global_en_nxt;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         enable_a_r <= `PIEF_RST8;
         enable_b_r <= `PIEF_RST5;
      end else begin
         enable_a_r <= enable_a_nxt;
         enable_b_r <= enable_b_nxt;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pending_a_r <= `PIEF_RST8;
         pending_b_r <= `PIEF_RST5;
      end else begin
         pending_a_r <= pending_a_nxt;
         pending_b_r <= pending_b_nxt;
      end
   end

   // block status and mask
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sts_r  <= `PIEF_RST2;
         mask_r <= `PIEF_RST2;
      end else begin
         sts_r  <= sts_nxt;
         mask_r <= mask_nxt;
      end
   end

   // request outputs
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         periph_req_r <= 1'b0;
         core_req_r   <= 1'b0;
         irq_r        <= 1'b0;
      end else begin
         periph_req_r <= periph_req;
         core_req_r   <= core_req;
         irq_r        <= |(sts_r & mask_r);
      end
   end

   assign PREADY         = pready_r;
   assign PRDATA         = prdata_r;
   assign PSLVERR        = pslverr_r;
   assign PERIPH_IRQ_REQ = periph_req_r;
   assign CORE_IRQ_REQ   = core_req_r;
   assign IRQ            = irq_r;

endmodule

// ===== verif/pief_asserts.sv
`timescale 1ns/1ps
`include "pief_defines.svh"
module pief_asserts (
   input wire logic                  MCLK,
   input wire logic                  RESETN,
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PWRITE,
   input wire logic [7:0]            PADDR,
   input wire logic                  PREADY,
   input wire logic [31:0]           PRDATA,
   input wire logic                  PSLVERR,
   input wire pief_pkg::pief_src_a_t EVT_A,
   input wire pief_pkg::pief_src_b_t EVT_B,
   input wire logic                  IRQ_ENTRY,
   input wire logic                  PERIPH_IRQ_REQ,
   input wire logic                  CORE_IRQ_REQ,
   input wire logic                  IRQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   sequence quiet_s;
      !PSEL && EVT_A == 8'h00 && EVT_B == 5'h00;
   endsequence
   sequence rd_ans_s;
      PREADY && !PWRITE;
   endsequence
   rdy_after_access_a: assert property ($rose(PSEL && PENABLE) |=> PREADY)
      else $error("ready late");
   rdy_one_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready too long");
   err_with_rdy_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   rst_outputs_low_a: assert property (
      $rose(RESETN) |-> !PERIPH_IRQ_REQ && !CORE_IRQ_REQ && !IRQ) else $error("busy after reset");
   enb_low_zero_a: assert property (
      rd_ans_s ##0 PADDR == `PIEF_OFF_EN_B |-> PRDATA[2:0] == 3'h0) else $error("enable b low");
   pendb_low_zero_a: assert property (
      rd_ans_s ##0 PADDR == `PIEF_OFF_PEND_B |-> PRDATA[2:0] == 3'h0) else $error("pend b low");
   core_needs_periph_a: assert property (CORE_IRQ_REQ |-> PERIPH_IRQ_REQ)
      else $error("core without periph");
   entry_drops_core_a: assert property (IRQ_ENTRY |=> ##1 !CORE_IRQ_REQ)
      else $error("core after entry");
   periph_stays_low_a: assert property (
      quiet_s ##1 !PERIPH_IRQ_REQ |=> !PERIPH_IRQ_REQ) else $error("periph rose unprompted");
endmodule
bind pief_top pief_asserts pief_asserts_i (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR), .EVT_A(EVT_A), .EVT_B(EVT_B), .IRQ_ENTRY(IRQ_ENTRY),
   .PERIPH_IRQ_REQ(PERIPH_IRQ_REQ), .CORE_IRQ_REQ(CORE_IRQ_REQ), .IRQ(IRQ));

// ===== verif/pief_evt_model.sv
`timescale 1ns/1ps
module pief_evt_model (
   input  wire logic             clk,
   input  wire logic             go,
   input  wire logic [7:0]       req_a,
   input  wire logic [4:0]       req_b,
   input  wire logic [1:0]       uart_lvl,
   output pief_pkg::pief_src_a_t evt_a,
   output pief_pkg::pief_src_b_t evt_b
);
   initial begin
      evt_a = 8'h00;
      evt_b = 5'h00;
   end
   always @(posedge clk) begin
      evt_a <= (go ? req_a & 8'hCF : 8'h00) | {2'h0, uart_lvl, 4'h0};
      evt_b <= go ? req_b : 5'h00;
   end
endmodule

// ===== verif/tb_peripheral_interrupt_enable_flags.sv
`timescale 1ns/1ps
`include "pief_defines.svh"
module tb_peripheral_interrupt_enable_flags;
   logic                  MCLK, RESETN, PSEL, PENABLE, PWRITE, IRQ_ENTRY, IRQ_RETURN;
   logic                  PREADY, PSLVERR, PERIPH_IRQ_REQ, CORE_IRQ_REQ, IRQ, go;
   logic [7:0]            PADDR, req_a;
   logic [31:0]           PWDATA, PRDATA, r;
   logic [4:0]            req_b;
   logic [1:0]            lvl;
   logic [32:0]           exp_q[$];
   pief_pkg::pief_src_a_t EVT_A;
   pief_pkg::pief_src_b_t EVT_B;
   int                    n_errors, n_checks, cyc;
   pief_top pief_top_i (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EVT_A(EVT_A), .EVT_B(EVT_B),
      .IRQ_ENTRY(IRQ_ENTRY), .IRQ_RETURN(IRQ_RETURN), .PERIPH_IRQ_REQ(PERIPH_IRQ_REQ),
      .CORE_IRQ_REQ(CORE_IRQ_REQ), .IRQ(IRQ));
   pief_evt_model pief_evt_model_i (.clk(MCLK), .go(go), .req_a(req_a), .req_b(req_b),
      .uart_lvl(lvl), .evt_a(EVT_A), .evt_b(EVT_B));
   always #20 MCLK = ~MCLK;
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [32:0] x, input logic [32:0] g);
      n_checks++;
      if (g !== x) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic chk(input string n, input logic x, ref logic g);
      repeat (2) @(posedge MCLK);
      cmp(n, {32'h0, x}, {32'h0, g});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      @(posedge MCLK iff PREADY);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic fire(input logic [7:0] a, input logic [4:0] b);
      go <= 1'b1;
      req_a <= a;
      req_b <= b;
      @(posedge MCLK);
      go <= 1'b0;
      repeat (3) @(posedge MCLK);
   endtask
   always @(posedge MCLK) begin
      if (PSEL && PENABLE && PREADY && !PWRITE) begin
         cmp("rdata", exp_q.pop_front(), {PSLVERR, PRDATA});
      end
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      {MCLK, RESETN, PSEL, PENABLE, PWRITE, IRQ_ENTRY, IRQ_RETURN, go} = 8'h00;
      {PADDR, PWDATA, req_a, req_b, lvl} = 55'h0;
      r = $urandom(32'hC532);
      repeat (8) @(posedge MCLK);
      RESETN <= 1'b1;
      @(posedge MCLK);
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), 33'h0);
      end
      rd(8'h1C, {1'b1, 32'h0});
      apb(1'b1, `PIEF_OFF_PEND_A, 32'h0);
      apb(1'b1, `PIEF_OFF_EN_A, 32'hFF);
      apb(1'b1, `PIEF_OFF_EN_B, 32'hFF);
      rd(`PIEF_OFF_EN_A, 33'hFF);
      rd(`PIEF_OFF_EN_B, 33'hF8);
      apb(1'b1, `PIEF_OFF_PEND_A, 32'hFF);
      rd(`PIEF_OFF_PEND_A, 33'hCF);
      chk("periph", 1'b0, PERIPH_IRQ_REQ);
      apb(1'b1, `PIEF_OFF_CTRL, 32'h40);
      chk("periph", 1'b1, PERIPH_IRQ_REQ);
      chk("core", 1'b0, CORE_IRQ_REQ);
      apb(1'b1, `PIEF_OFF_CTRL, 32'hC0);
      chk("core", 1'b1, CORE_IRQ_REQ);
      IRQ_ENTRY <= 1'b1;
      @(posedge MCLK);
      IRQ_ENTRY <= 1'b0;
      chk("core", 1'b0, CORE_IRQ_REQ);
      IRQ_RETURN <= 1'b1;
      @(posedge MCLK);
      IRQ_RETURN <= 1'b0;
      chk("core", 1'b1, CORE_IRQ_REQ);
      apb(1'b1, `PIEF_OFF_PEND_A, 32'h0);
      chk("periph", 1'b0, PERIPH_IRQ_REQ);
      r = $urandom;
      fire(r[7:0] | 8'h01, r[12:8]);
      rd(`PIEF_OFF_PEND_A, {25'h0, (r[7:0] & 8'hCF) | 8'h01});
      rd(`PIEF_OFF_PEND_B, {25'h0, r[12:8], 3'h0});
      chk("periph", 1'b1, PERIPH_IRQ_REQ);
      fork
         apb(1'b1, `PIEF_OFF_PEND_A, 32'h0);
         begin
            @(posedge MCLK);
            go <= 1'b1;
            req_a <= 8'h01;
            @(posedge MCLK);
            go <= 1'b0;
         end
      join
      rd(`PIEF_OFF_PEND_A, 33'h01);
      lvl <= 2'b11;
      repeat (3) @(posedge MCLK);
      apb(1'b1, `PIEF_OFF_PEND_A, 32'h0);
      rd(`PIEF_OFF_PEND_A, 33'h30);
      lvl <= 2'b00;
      apb(1'b1, `PIEF_OFF_EN_A, 32'h0);
      apb(1'b1, `PIEF_OFF_STS, 32'hFF);
      apb(1'b1, `PIEF_OFF_MASK, 32'h02);
      chk("irq", 1'b0, IRQ);
      fire(8'h04, 5'h00);
      chk("irq", 1'b1, IRQ);
      apb(1'b1, `PIEF_OFF_MASK, 32'h0);
      chk("irq", 1'b0, IRQ);
      apb(1'b1, `PIEF_OFF_MASK, 32'h02);
      apb(1'b1, `PIEF_OFF_STS, 32'h02);
      chk("irq", 1'b0, IRQ);
      RESETN <= 1'b0;
      repeat (2) @(posedge MCLK);
      RESETN <= 1'b1;
      @(posedge MCLK);
      rd(`PIEF_OFF_CTRL, 33'h0);
      rd(`PIEF_OFF_EN_B, 33'h0);
      rd(`PIEF_OFF_PEND_A, 33'h0);
      apb(1'b1, `PIEF_OFF_PEND_B, 32'hFF);
      rd(`PIEF_OFF_PEND_B, 33'hF8);
      apb(1'b1, `PIEF_OFF_EN_A, 32'h01);
      apb(1'b1, `PIEF_OFF_CTRL, 32'h40);
      apb(1'b1, `PIEF_OFF_MASK, 32'h01);
      chk("irq", 1'b0, IRQ);
      fire(8'h01, 5'h00);
      chk("periph", 1'b1, PERIPH_IRQ_REQ);
      chk("irq", 1'b1, IRQ);
      stop_test();
   end
endmodule
